// file: hdl/inactivity_power_state_manager.sv
// Purpose: Inactivity timers, power state machine, throttle and gating control
// Assumes: Activity inputs synchronous to aclk; AXI4-Lite register slave
// Notes:   Times counted in 4 ms ticks
// Notes on behaviour
// RL1: Full-on inactivity timeout enters standby
// RL2: Standby inactivity timeout enters suspend
// RL3: Timer unit 32s, 4ms, 4min, 4s
// RL4: Per-line monitor or ignore selection
// RL5: Monitored activity returns to full-on
// RL6: Monitored activity reloads standby and suspend timers
// RL7: Default monitor lines 0 and 6 only
// RL8: Throttle stop-clock duty in eighths
// RL9: Display monitoring counts display activity
// RL10: Disk timeout 1-15 minutes or disabled
// RL11: Disk power-down state selectable
// RL12: Video power-down state selectable
// RL13: Monitor power state selectable
// RL14: Power button toggles by mode
// RL15: Gate clocks when all buses idle
// RL16: Power states advance only in order; a button press takes full-on straight to suspend or off
// RL17: Disabled timeout stops its timer
//
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module inactivity_power_state_manager
#(
  // Cycles per 4 ms tick; a bench may shorten it to keep runs brief
  parameter int unsigned TICK_LEN = pwr_mgr_pkg::TICK_CYC
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [8:0]  irq_activity,
  input  wire logic        display_activity,
  input  wire logic        disk_activity,
  input  wire logic        power_button,
  input  wire logic        thermal_throttle,
  input  wire logic        buses_idle,
  output logic [3:0]       power_state,
  output logic             processor_stop_clock_request,
  output logic             internal_clock_gate_enable,
  output logic [1:0]       disk_power_state,
  output logic [1:0]       video_power_state,
  output logic [1:0]       monitor_power_state
);
  import pwr_mgr_pkg::*;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ****************************************
  // Registers and bus slave
  // ****************************************
  logic [31:0] ctrl_reg;
  logic [31:0] timer_reg;
  logic [8:0]  monitor_reg;
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        do_write;
  ctrl_s       ctrl;
  pstate_e     state_reg;
  logic        disk_down_reg;
  logic        video_down_reg;

  assign ctrl          = ctrl_s'(ctrl_reg[11:0]);
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign do_write      = aw_held_reg && w_held_reg && !s_axi_bvalid;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[8*i +: 8] = d[8*i +: 8];
    return r;
  endfunction : merge

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      awaddr_reg   <= 8'h00;
      wdata_reg    <= 32'h0000_0000;
      wstrb_reg    <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_reg == CTRL_OFS || awaddr_reg == TIMER_OFS ||
                         awaddr_reg == MONITOR_OFS || awaddr_reg == CMD_OFS) ? 2'b00 : 2'b10;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg    <= CTRL_RESET;
      timer_reg   <= TIMER_RESET;
      monitor_reg <= MON_RESET; // RL7
    end
    else if (do_write)
    begin
      unique case (awaddr_reg)
        CTRL_OFS:    ctrl_reg  <= merge(ctrl_reg, wdata_reg, wstrb_reg) & 32'h0000_0fff;
        TIMER_OFS:   timer_reg <= merge(timer_reg, wdata_reg, wstrb_reg) & 32'h00f3_ffff;
        MONITOR_OFS: monitor_reg <= 9'(merge({23'h00_0000, monitor_reg}, wdata_reg, wstrb_reg))
                                    & MON_VALID; // RL4
        CMD_OFS:     if (wstrb_reg[0] && wdata_reg[0]) monitor_reg <= MON_FAILSAFE; // RL7
        default:     ;
      endcase
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'b00;
      unique case (s_axi_araddr[7:0])
        CTRL_OFS:    s_axi_rdata <= ctrl_reg;
        TIMER_OFS:   s_axi_rdata <= timer_reg;
        MONITOR_OFS: s_axi_rdata <= {23'h00_0000, monitor_reg};
        CMD_OFS:     s_axi_rdata <= 32'h0000_0000;
        STATUS_OFS:  s_axi_rdata <= {26'h000_0000, video_down_reg, disk_down_reg, state_reg};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ****************************************
  // Activity and timers
  // ****************************************
  logic        tick;
  logic        activity;
  logic [23:0] unit_ticks;
  logic [23:0] stby_period;
  logic [23:0] susp_period;
  logic [23:0] disk_period;
  logic        stby_exp;
  logic        susp_exp;
  logic        disk_exp;
  logic        button_d_reg;
  logic        press;

  // Only monitored lines count; display joins when selected
  assign activity = (|(irq_activity & monitor_reg)) // RL4
                    || (ctrl.display_monitor && display_activity); // RL9

  always_comb
  begin
    unique case (unit_e'(timer_reg[UNIT_LSB +: 2])) // RL3
      UNIT_32S:  unit_ticks = 24'(UNIT_32S_TICKS);
      UNIT_4MS:  unit_ticks = 24'(UNIT_4MS_TICKS);
      UNIT_4MIN: unit_ticks = 24'(UNIT_4MIN_TICKS);
      UNIT_4S:   unit_ticks = 24'(UNIT_4S_TICKS);
    endcase
  end

  // Field steps are units, so 127 x 4 min = 508 min at the 4 min unit
  assign stby_period = 24'(timer_reg[STBY_LSB +: 7] * unit_ticks); // RL1
  assign susp_period = 24'(timer_reg[SUSP_LSB +: 7] * unit_ticks); // RL2
  assign disk_period = 24'(timer_reg[DISK_LSB +: 4] * 24'(MIN_TICKS)); // RL10

  tick_divider #(.CYCLES(TICK_LEN)) u_div
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick)
  );

  // Reload on activity or on entering a new state so each period starts fresh
  inact_timer u_stby
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick && state_reg == ST_FULL_ON),
    .reload  (activity || state_reg != ST_FULL_ON), // RL6
    .period  (stby_period),
    .expired (stby_exp)
  );

  inact_timer u_susp
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick && state_reg == ST_STANDBY),
    .reload  (activity || state_reg != ST_STANDBY), // RL6
    .period  (susp_period),
    .expired (susp_exp)
  );

  inact_timer u_disk
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick),
    .reload  (disk_activity),
    .period  (disk_period),
    .expired (disk_exp)
  );

  assign press = power_button && !button_d_reg;

  // ****************************************
  // Power state machine
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg    <= ST_FULL_ON;
      button_d_reg <= 1'b0;
    end
    else
    begin
      button_d_reg <= power_button;
      unique case (state_reg)
        ST_FULL_ON:
          if (press)
            state_reg <= ctrl.button_suspend ? ST_SUSPEND : ST_OFF; // RL14
          else if (stby_exp && !activity && stby_period != 24'h00_0000)
            state_reg <= ST_STANDBY; // RL1
        ST_STANDBY:
          if (activity || press)
            state_reg <= ST_FULL_ON; // RL5
          else if (susp_exp)
            state_reg <= ST_SUSPEND; // RL2
        ST_SUSPEND:
          if (activity || press)
            state_reg <= ST_FULL_ON; // RL5
        ST_OFF:
          if (press)
            state_reg <= ST_FULL_ON; // RL14
        default:
          state_reg <= ST_FULL_ON;
      endcase
    end
  end

  assign power_state = state_reg; // RL16

  // ****************************************
  // Device power-down outputs
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      disk_down_reg       <= 1'b0;
      video_down_reg      <= 1'b0;
      disk_power_state    <= PD_OFF;
      video_power_state   <= PD_OFF;
      monitor_power_state <= MON_STANDBY;
    end
    else
    begin
      disk_down_reg  <= disk_exp && ctrl.disk_pd != PD_OFF; // RL10
      disk_power_state <= disk_exp ? ctrl.disk_pd : PD_OFF; // RL11
      video_down_reg <= ctrl.display_monitor && state_reg != ST_FULL_ON
                        && ctrl.video_pd != PD_OFF;
      video_power_state <= (ctrl.display_monitor && state_reg != ST_FULL_ON)
                           ? ctrl.video_pd : PD_OFF; // RL12
      monitor_power_state <= ctrl.monitor_state; // RL13
    end
  end

  // ****************************************
  // Throttle and clock gating
  // ****************************************
  logic [2:0] phase_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      phase_reg                    <= 3'd0;
      processor_stop_clock_request <= 1'b0;
      internal_clock_gate_enable   <= 1'b0;
    end
    else
    begin
      phase_reg <= phase_reg + 3'd1;
      // Ratio n of 1..7 asserts n-1 of each 8 slots, the first n-1 slots of each period
      processor_stop_clock_request <= thermal_throttle && ctrl.slow_ratio != 3'd0
                                      && (phase_reg < ctrl.slow_ratio - 3'd1); // RL8
      internal_clock_gate_enable   <= ctrl.gate_en && buses_idle; // RL15
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_activity_wakes;
    (activity && (state_reg == ST_STANDBY || state_reg == ST_SUSPEND))
      |=> state_reg == ST_FULL_ON;
  endproperty
  a_activity_wakes : assert property (p_activity_wakes) else $error("no wake on activity"); // RL5
  property p_ignored_line;
    (state_reg == ST_SUSPEND && !activity && !press) |=> state_reg == ST_SUSPEND;
  endproperty
  a_ignored_line : assert property (p_ignored_line) else $error("suspend left without cause"); // RL4
  property p_standby_entry;
    ($changed(state_reg) && state_reg == ST_STANDBY)
      |-> $past(stby_exp) && $past(state_reg == ST_FULL_ON);
  endproperty
  a_standby_entry : assert property (p_standby_entry) else $error("standby without expiry"); // RL1
  property p_suspend_entry;
    ($changed(state_reg) && state_reg == ST_SUSPEND && !$past(press)) |-> $past(susp_exp);
  endproperty
  a_suspend_entry : assert property (p_suspend_entry) else $error("suspend without expiry"); // RL2
  property p_order;
    (state_reg == ST_SUSPEND) |=> (state_reg == ST_SUSPEND || state_reg == ST_FULL_ON);
  endproperty
  a_order : assert property (p_order) else $error("illegal state order"); // RL16
  property p_disabled_stby;
    (timer_reg[6:0] == 7'd0 && state_reg == ST_FULL_ON) |=> state_reg != ST_STANDBY;
  endproperty
  a_disabled_stby : assert property (p_disabled_stby) else $error("disabled standby fired"); // RL17
  property p_throttle_off;
    (!thermal_throttle || ctrl.slow_ratio == 3'd0) |=> !processor_stop_clock_request;
  endproperty
  a_throttle_off : assert property (p_throttle_off) else $error("stop clock while not throttling"); // RL8
  property p_gate;
    internal_clock_gate_enable |-> $past(ctrl.gate_en) && $past(buses_idle);
  endproperty
  a_gate : assert property (p_gate) else $error("gating without idle"); // RL15
  property p_button_off;
    (press && state_reg == ST_FULL_ON && !ctrl.button_suspend) |=> state_reg == ST_OFF;
  endproperty
  a_button_off : assert property (p_button_off) else $error("button did not switch off"); // RL14

  c_standby : cover property (@(posedge aclk) state_reg == ST_STANDBY);
  c_suspend : cover property (@(posedge aclk) state_reg == ST_SUSPEND);
  c_wake    : cover property (@(posedge aclk) state_reg == ST_SUSPEND ##1 state_reg == ST_FULL_ON);
  c_processor_stop_clock_request  : cover property (@(posedge aclk) processor_stop_clock_request);
endmodule : inactivity_power_state_manager

// file: hdl/pwr_mgr_pkg.sv
// Purpose: Shared constants and types for the inactivity power state manager
// Assumes: 50 MHz clock, AXI4-Lite register access with 32-bit data
// Notes:   Offsets are byte addresses of aligned words
package pwr_mgr_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned TICK_MS         = 4;
  localparam int unsigned TICK_CYC        = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned UNIT_4MS_TICKS  = 1;
  localparam int unsigned UNIT_4S_TICKS   = 1000;
  localparam int unsigned UNIT_32S_TICKS  = 8000;
  localparam int unsigned UNIT_4MIN_TICKS = 60000;
  localparam int unsigned MIN_TICKS       = 15000;
  localparam int unsigned THR_PERIOD      = 8;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] TIMER_OFS   = 8'h04;
  localparam logic [7:0] MONITOR_OFS = 8'h08;
  localparam logic [7:0] CMD_OFS     = 8'h0C;
  localparam logic [7:0] STATUS_OFS  = 8'h10;

  // Timer register fields
  localparam int unsigned STBY_LSB  = 0;
  localparam int unsigned SUSP_LSB  = 8;
  localparam int unsigned UNIT_LSB  = 16;
  localparam int unsigned DISK_LSB  = 20;

  // Monitor register bits: 0..3 disk positions, 5 floppy, 6/7 serial, 8 parallel
  localparam logic [8:0] MON_RESET    = 9'h041;
  localparam logic [8:0] MON_FAILSAFE = 9'h1ef;
  localparam logic [8:0] MON_VALID    = 9'h1ef;

  // Ctrl register reset: ratio 5, on/off button, display monitored, standby disk and video, monitor suspend
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0a55;
  localparam logic [31:0] TIMER_RESET = 32'h0000_0000;

  typedef enum logic [1:0] { UNIT_32S = 2'd0, UNIT_4MS = 2'd1, UNIT_4MIN = 2'd2, UNIT_4S = 2'd3 }
    unit_e;
  typedef enum logic [1:0] { PD_OFF = 2'd0, PD_STANDBY = 2'd1, PD_SUSPEND = 2'd2 } pd_mode_e;
  typedef enum logic [1:0] { MON_STANDBY = 2'd0, MON_SUSPEND = 2'd1, MON_OFF = 2'd2 } mon_state_e;
  typedef enum logic [3:0]
  {
    ST_FULL_ON = 4'b0001,
    ST_STANDBY = 4'b0010,
    ST_SUSPEND = 4'b0100,
    ST_OFF     = 4'b1000
  } pstate_e;

  typedef struct packed {
    logic [2:0] slow_ratio;
    logic       gate_en;
    logic       button_suspend;
    logic       display_monitor;
    logic [1:0] monitor_state;
    logic [1:0] video_pd;
    logic [1:0] disk_pd;
  } ctrl_s;

endpackage : pwr_mgr_pkg

// file: hdl/inact_timer.sv
// Purpose: Reloadable down-counter of tick pulses with expiry flag
// Assumes: Period zero means disabled
// Notes:   Expired stays high until reload or a zero period
`timescale 1ns/100ps
module inact_timer
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        tick,
  input  wire logic        reload,
  input  wire logic [23:0] period,
  output logic             expired
);
  import pwr_mgr_pkg::*;

  logic [23:0] count_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || reload)
    begin
      count_reg <= period;
      expired   <= 1'b0;
    end
    else if (period == 24'h00_0000)
    begin
      expired   <= 1'b0; // RL17
    end
    else if (tick)
    begin
      if (count_reg <= 24'h00_0001)
        expired <= 1'b1;
      else
        count_reg <= count_reg - 24'h00_0001;
    end
  end

  property p_disabled_never;
    @(posedge aclk) disable iff (!aresetn)
    (period == 24'h00_0000) |=> !expired;
  endproperty
  a_disabled_never : assert property (p_disabled_never) else $error("disabled timer expired"); // RL17
endmodule : inact_timer

// file: hdl/tick_divider.sv
// Purpose: Divide the clock to a 4 ms one-cycle enable pulse
// Assumes: Single clock
// Notes:   Count length set in the package
`timescale 1ns/100ps
module tick_divider
#(
  parameter int unsigned CYCLES = pwr_mgr_pkg::TICK_CYC
)
(
  input  wire logic aclk,
  input  wire logic aresetn,
  output logic      tick
);
  import pwr_mgr_pkg::*;

  localparam logic [17:0] LAST = 18'(CYCLES - 1);
  logic [17:0] cnt_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_reg <= 18'h0_0000;
      tick    <= 1'b0;
    end
    else
    begin
      tick    <= (cnt_reg == LAST);
      cnt_reg <= (cnt_reg == LAST) ? 18'h0_0000 : cnt_reg + 18'h0_0001;
    end
  end
endmodule : tick_divider

// file: verif/periph_host_model.sv
// Purpose: Far side model: peripheral request lines, power button, processor stop-clock input
// Assumes: Bench commands arrive as one-cycle strobes after a rising edge
// Notes:   Lines are inactive low once a pulse is over
`timescale 1ns/100ps
module periph_host_model
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [8:0] irq_cmd,
  input  wire logic       press_cmd,
  input  wire logic       count_clr,
  input  wire logic       processor_stop_clock_request,
  output logic      [8:0] irq_activity,
  output logic            power_button,
  output logic      [7:0] stop_count
);
  logic [1:0] btn_cnt;

  // ****************************************
  // Request lines pulse for one cycle
  // ****************************************
  always_ff @(posedge aclk)
    irq_activity <= aresetn ? irq_cmd : 9'h000;

  // Button held a few cycles so a press is one clean rising edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      btn_cnt <= 2'd0;
    else if (press_cmd)
      btn_cnt <= 2'd3;
    else if (btn_cnt != 2'd0)
      btn_cnt <= btn_cnt - 2'd1;
  end
  assign power_button = (btn_cnt != 2'd0);

  // ****************************************
  // Processor side counts stop-clock cycles
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn || count_clr)
      stop_count <= 8'h00;
    else if (processor_stop_clock_request)
      stop_count <= stop_count + 8'h01;
  end
endmodule : periph_host_model

// file: verif/inactivity_power_state_manager_tb.sv
// Purpose: Self-checking bench for the inactivity power state manager
// Assumes: AXI4-Lite master tasks; 4 ms timer unit keeps the timer run short
// Notes:   Expected values come from an integer model kept in the bench
`timescale 1ns/100ps
module inactivity_power_state_manager_tb;
  import pwr_mgr_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0000_0000, s_axi_wdata = 32'h0000_0000;
  logic [31:0] s_axi_araddr = 32'h0000_0000, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, disk_power_state, video_power_state, monitor_power_state;
  logic [8:0] irq_activity, irq_cmd = 9'h000;
  logic display_activity = 1'b0, disk_activity = 1'b0, thermal_throttle = 1'b0;
  logic buses_idle = 1'b0, press_cmd = 1'b0, count_clr = 1'b0, power_button;
  logic [3:0] power_state, mstate;
  logic processor_stop_clock_request, internal_clock_gate_enable;
  logic [7:0] stop_count;
  logic [31:0] mctrl, mmask, rnd, rd;
  logic [1:0] rs;
  logic prev;
  int bad_count = 0, cmp_count = 0, cyc = 0;
  logic [31:0] rst_q[$];

  always #10 aclk = ~aclk;

  inactivity_power_state_manager #(.TICK_LEN(64)) uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq_activity(irq_activity),
    .display_activity(display_activity), .disk_activity(disk_activity),
    .power_button(power_button), .thermal_throttle(thermal_throttle), .buses_idle(buses_idle),
    .power_state(power_state), .processor_stop_clock_request(processor_stop_clock_request),
    .internal_clock_gate_enable(internal_clock_gate_enable),
    .disk_power_state(disk_power_state), .video_power_state(video_power_state),
    .monitor_power_state(monitor_power_state));

  periph_host_model partner (.aclk(aclk), .aresetn(aresetn), .irq_cmd(irq_cmd),
    .press_cmd(press_cmd), .count_clr(count_clr),
    .processor_stop_clock_request(processor_stop_clock_request),
    .irq_activity(irq_activity), .power_button(power_button), .stop_count(stop_count));

  // ****************************************
  // Reporting
  // ****************************************
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_reg

  task automatic cmp_st(input logic [3:0] got, input logic [3:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t state got %h exp %h", $time, got, exp);
    end
  endtask : cmp_st

  // Whole run is about 1,000 cycles with the shortened 64-cycle tick
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      results();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs

  // ****************************************
  // Bus master and stimulus tasks
  // ****************************************
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    done = 1'b0;
    while (!done)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    done = 1'b0;
    while (!done)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : axi_rd

  task automatic pulse(input logic [8:0] lines, input logic btn);
    @(posedge aclk);
    irq_cmd <= lines;
    press_cmd <= btn;
    @(posedge aclk);
    irq_cmd <= 9'h000;
    press_cmd <= 1'b0;
    repeat (8) @(posedge aclk);
    if (btn) mstate = (mstate != ST_FULL_ON) ? ST_FULL_ON : (mctrl[7] ? ST_SUSPEND : ST_OFF);
    if (mstate != ST_FULL_ON && (lines & mmask[8:0]) != 9'h000) mstate = ST_FULL_ON;
    @(negedge aclk);
  endtask : pulse

  task automatic wait_state(input logic [3:0] s);
    int n;
    n = 0;
    while (power_state !== s && n < 1000)
    begin
      @(negedge aclk);
      n++;
    end
    mstate = s;
  endtask : wait_state

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    rnd = 32'h909b;
    mstate = ST_FULL_ON;
    mctrl = CTRL_RESET;
    mmask = {23'h0, MON_RESET};
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    cmp_st(power_state, ST_FULL_ON);
    cmp_reg({26'h0, processor_stop_clock_request, internal_clock_gate_enable,
             disk_power_state, video_power_state}, 32'h0000_0000);
    rst_q = '{CTRL_RESET, TIMER_RESET, 32'h0000_0041, 32'h0000_0000, 32'h0000_0001};
    foreach (rst_q[i])
    begin
      axi_rd(i * 4, rd, rs);
      if (i != 3) cmp_reg(rd, rst_q[i]);
    end
    axi_rd(32'h0000_0014, rd, rs);
    cmp_reg({30'h0, rs}, 32'h0000_0002);
    axi_wr(32'h0000_0018, 32'h0000_ffff, rs);
    cmp_reg({30'h0, rs}, 32'h0000_0002);
    repeat (3)
    begin
      rnd = xs(rnd);
      axi_wr({24'h0, MONITOR_OFS}, rnd, rs);
      axi_rd({24'h0, MONITOR_OFS}, rd, rs);
      cmp_reg(rd, rnd & {23'h0, MON_VALID});
    end
    axi_wr({24'h0, CMD_OFS}, 32'h0000_0001, rs);
    axi_rd({24'h0, MONITOR_OFS}, rd, rs);
    cmp_reg(rd, {23'h0, MON_FAILSAFE});
    // Button modes; ignored lines leave the state alone, monitored lines wake from suspend
    for (int m = 1; m >= 0; m--)
    begin
      mctrl = CTRL_RESET | (m << 7);
      axi_wr({24'h0, CTRL_OFS}, mctrl, rs);
      rnd = xs(rnd);
      mmask = (rnd & 32'h0000_00ef) | 32'h0000_0020;
      axi_wr({24'h0, MONITOR_OFS}, mmask, rs);
      pulse(9'h000, 1'b1);
      cmp_st(power_state, mstate);
      cmp_reg({30'h0, video_power_state}, {30'h0, mctrl[3:2]});
      pulse(~mmask[8:0] & MON_VALID, 1'b0);
      cmp_st(power_state, mstate);
      pulse(m ? mmask[8:0] : 9'h000, !m);
      cmp_st(power_state, mstate);
    end
    // Gate follows enable and idle buses one cycle late
    axi_wr({24'h0, CTRL_OFS}, 32'h0000_0100, rs);
    prev = 1'b0;
    repeat (32)
    begin
      @(posedge aclk);
      rnd = xs(rnd);
      buses_idle <= rnd[0];
      @(negedge aclk);
      cmp_reg({31'h0, internal_clock_gate_enable}, {31'h0, prev});
      prev = rnd[0];
    end
    thermal_throttle <= 1'b1;
    for (int r = 0; r < 8; r++)
    begin
      axi_wr({24'h0, CTRL_OFS}, r << 9, rs);
      repeat (16) @(posedge aclk);
      count_clr <= 1'b1;
      @(posedge aclk);
      count_clr <= 1'b0;
      repeat (64) @(posedge aclk);
      @(negedge aclk);
      cmp_reg({24'h0, stop_count}, (r == 0) ? 0 : (r - 1) * 8);
    end
    thermal_throttle <= 1'b0;
    cmp_st(power_state, mstate);
    // One-tick standby and suspend periods in the 4 ms unit
    mctrl = 32'h0000_0058;
    axi_wr({24'h0, CTRL_OFS}, mctrl, rs);
    @(negedge aclk);
    cmp_reg({30'h0, monitor_power_state}, {30'h0, mctrl[5:4]});
    axi_wr({24'h0, TIMER_OFS}, 32'h0001_0101, rs);
    wait_state(ST_STANDBY);
    cmp_st(power_state, ST_STANDBY);
    wait_state(ST_SUSPEND);
    cmp_st(power_state, ST_SUSPEND);
    cmp_reg({30'h0, video_power_state}, {30'h0, mctrl[3:2]});
    @(posedge aclk);
    display_activity <= 1'b1;
    @(posedge aclk);
    display_activity <= 1'b0;
    @(negedge aclk);
    cmp_st(power_state, ST_FULL_ON);
    results();
  end
endmodule : inactivity_power_state_manager_tb
